// ---- rtl/usbrm_regs.svh ----
`ifndef USBRM_REGS_SVH
`define USBRM_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USBRM_OTGIR_OFS   16'h5040
`define USBRM_OTGIE_OFS   16'h5050
`define USBRM_OTGSTAT_OFS 16'h5060
`define USBRM_OTGCON_OFS  16'h5070
`define USBRM_PWRC_OFS    16'h5080
`define USBRM_IR_OFS      16'h5200
`define USBRM_IE_OFS      16'h5210
`define USBRM_EIR_OFS     16'h5220
`define USBRM_EIE_OFS     16'h5230
`define USBRM_STAT_OFS    16'h5240
`define USBRM_CON_OFS     16'h5250
`define USBRM_ADDR_OFS    16'h5260
`define USBRM_BDTP_OFS    16'h5270
// ----------------------------------------
// implemented bits per register, the rest read zero
// ----------------------------------------
`define USBRM_OTGIR_MASK   8'hFD
`define USBRM_OTGIE_MASK   8'hFD
`define USBRM_OTGSTAT_MASK 8'hAD
`define USBRM_OTGCON_MASK  8'hFF
`define USBRM_PWRC_MASK    8'h9B
`define USBRM_IE_MASK      8'hFF
`define USBRM_EIE_MASK     8'hFF
`define USBRM_STAT_MASK    8'hFC
`define USBRM_CON_MASK     8'hFF
`define USBRM_ADDR_MASK    8'hFF
`define USBRM_BDTP_MASK    8'hFE
// ----------------------------------------
// alias offsets, field positions, reset values
// ----------------------------------------
`define USBRM_ALIAS_CLR   2'd1
`define USBRM_ALIAS_SET   2'd2
`define USBRM_ALIAS_INV   2'd3
`define USBRM_PACKET_ID_CHECK_ERROR_FLAG_BIT   0
`define USBRM_TOKEN_CHECKSUM_ERROR_FLAG_BIT  1
`define USBRM_TURNAROUND_TIMEOUT_ERROR_FLAG_BIT   4
`define USBRM_MEMORY_ACCESS_ERROR_FLAG_BIT   5
`define USBRM_GENERAL_ERROR_INTERRUPT_FLAG_BIT  1
`define USBRM_HOSTEN_BIT  3
`define USBRM_REG_RESET   8'h00
`define USBRM_IDLE_BITS   16
`define USBRM_BIT_TIME_NS 83
`define USBRM_CLK_NS      10
`define USBRM_BIT_CYCLES  ((`USBRM_BIT_TIME_NS + `USBRM_CLK_NS - 1) / `USBRM_CLK_NS)
`endif

// ---- rtl/usbrm_pkg.sv ----
package usbrm_pkg;
  typedef enum logic [1:0] {USBRM_BASE, USBRM_CLR, USBRM_SET, USBRM_INV} usbrm_alias_t;
  typedef enum {USBRM_TA_IDLE, USBRM_TA_WAIT} usbrm_ta_state_t;
endpackage

// ---- rtl/usbrm_top.sv ----
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "usbrm_regs.svh"
module usbrm_top
  import usbrm_pkg::*;
#(
  parameter int IDLE_BITS  = `USBRM_IDLE_BITS,
  parameter int BIT_CYCLES = `USBRM_BIT_CYCLES
) (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [15:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // link engine events
  input  wire logic        I_TOKEN_CRC_BAD,
  input  wire logic        I_SOF_ZERO,
  input  wire logic        I_XFER_ACTIVE,
  input  wire logic        I_PID_BAD,
  input  wire logic        I_DMA_LATE,
  input  wire logic        I_RX_TRUNC,
  input  wire logic        I_EOP,
  input  wire logic        I_BUS_IDLE,
  input  wire logic        I_RESP_SEEN,
  input  wire logic [7:0]  I_OTG_EVENTS,
  input  wire logic [7:0]  I_GEN_EVENTS,
  input  wire logic [7:0]  I_OTG_LINES,
  input  wire logic [7:0]  I_XFER_STATUS,
  // interrupt
  output logic             O_IRQ
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [7:0]   otg_if;
  logic [7:0]   otg_ie;
  logic [7:0]   otg_con;
  logic [7:0]   pwrc;
  logic [7:0]   gen_if;
  logic [7:0]   gen_ie;
  logic [7:0]   err_if;
  logic [7:0]   err_ie;
  logic [7:0]   con;
  logic [7:0]   addr;
  logic [7:0]   bdtp;
  logic [15:0]  base_addr;
  usbrm_alias_t kind;
  logic         acc;
  logic         wr;
  logic         known;
  logic         alias_ok;
  logic [7:0]   wd;
  logic [7:0]   rd;

  assign kind      = usbrm_alias_t'(I_PADDR[3:2]);
  assign base_addr = {I_PADDR[15:4], 4'h0};
  assign acc       = I_PSEL && I_PENABLE;
  assign wd        = I_PWDATA[7:0];

  always_comb begin
    known = 1'b1;
    alias_ok = 1'b1;
    rd = 8'h00;
    unique case (base_addr)
      `USBRM_OTGIR_OFS: begin
        rd = otg_if;
        alias_ok = (kind == USBRM_BASE) || (kind == USBRM_CLR);
      end
      `USBRM_OTGIE_OFS: rd = otg_ie;
      `USBRM_OTGSTAT_OFS: begin
        rd = I_OTG_LINES & `USBRM_OTGSTAT_MASK;
        alias_ok = (kind == USBRM_BASE);
      end
      `USBRM_OTGCON_OFS: rd = otg_con;
      `USBRM_PWRC_OFS:   rd = pwrc;
      `USBRM_IR_OFS: begin
        rd = gen_if;
        alias_ok = (kind == USBRM_BASE) || (kind == USBRM_CLR);
      end
      `USBRM_IE_OFS:     rd = gen_ie;
      `USBRM_EIR_OFS: begin
        rd = err_if;
        alias_ok = (kind == USBRM_BASE) || (kind == USBRM_CLR);
      end
      `USBRM_EIE_OFS:    rd = err_ie;
      `USBRM_STAT_OFS: begin
        rd = I_XFER_STATUS & `USBRM_STAT_MASK;
        alias_ok = (kind == USBRM_BASE);
      end
      `USBRM_CON_OFS:    rd = con;
      `USBRM_ADDR_OFS:   rd = addr;
      `USBRM_BDTP_OFS:   rd = {bdtp[7:1], 1'b0};
      default:           known = 1'b0;
    endcase
  end

  assign wr = acc && I_PWRITE && known && alias_ok;

  // alias arithmetic: a base write replaces the value; on the clr, set and inv aliases only ones written change it
  function automatic logic [7:0] apply(input logic [7:0] cur, input usbrm_alias_t k, input logic [7:0] d);
    unique case (k)
      USBRM_BASE: apply = d;
      USBRM_CLR:  apply = cur & ~d;
      USBRM_SET:  apply = cur | d;
      USBRM_INV:  apply = cur ^ d;
    endcase
  endfunction

  // ----------------------------------------
  // apb answer, zero wait states
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
    end
  end

  // refusal decided in setup, so a refused write never lands
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PSLVERR <= 1'b0;
    end else begin
      O_PSLVERR <= I_PSEL && !I_PENABLE && !(known && alias_ok);
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PRDATA <= (kind == USBRM_BASE) ? {24'h00_0000, rd} : 32'h0000_0000;
    end
  end

  logic phase;
  assign phase = acc && O_PREADY;
  logic do_wr;
  assign do_wr = phase && wr;

  function automatic logic hit(input logic [15:0] ofs);
    hit = do_wr && (base_addr == ofs);
  endfunction

  // ----------------------------------------
  // plain control registers, one process per register
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      otg_ie <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_OTGIE_OFS)) begin
      otg_ie <= apply(otg_ie, kind, wd) & `USBRM_OTGIE_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      otg_con <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_OTGCON_OFS)) begin
      otg_con <= apply(otg_con, kind, wd) & `USBRM_OTGCON_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pwrc <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_PWRC_OFS)) begin
      pwrc <= apply(pwrc, kind, wd) & `USBRM_PWRC_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gen_ie <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_IE_OFS)) begin
      gen_ie <= apply(gen_ie, kind, wd) & `USBRM_IE_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      err_ie <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_EIE_OFS)) begin
      err_ie <= apply(err_ie, kind, wd) & `USBRM_EIE_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      con <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_CON_OFS)) begin
      con <= apply(con, kind, wd) & `USBRM_CON_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_ADDR_OFS)) begin
      addr <= apply(addr, kind, wd) & `USBRM_ADDR_MASK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bdtp <= `USBRM_REG_RESET;
    end else if (hit(`USBRM_BDTP_OFS)) begin
      bdtp <= apply(bdtp, kind, wd) & `USBRM_BDTP_MASK;
    end
  end

  // ----------------------------------------
  // turnaround timer, counts idle bit times after eop
  // ----------------------------------------
  usbrm_ta_state_t ta_state;
  usbrm_ta_state_t next_ta_state;
  logic [15:0]     bt_cnt;
  logic [15:0]     next_bt_cnt;
  logic [7:0]      bits;
  logic [7:0]      next_bits;
  logic            ta_timeout;
  logic            next_ta_timeout;
  logic            bit_end;

  assign bit_end = (bt_cnt == 16'(BIT_CYCLES - 1));

  // a reply or any bus activity ends the wait; only silence counts
  always_comb begin
    next_ta_state   = ta_state;
    next_bt_cnt     = bt_cnt;
    next_bits       = bits;
    next_ta_timeout = 1'b0;
    unique case (ta_state)
      USBRM_TA_IDLE: begin
        if (I_EOP) begin
          next_ta_state = USBRM_TA_WAIT;
          next_bt_cnt   = 16'h0000;
          next_bits     = 8'h00;
        end
      end
      USBRM_TA_WAIT: begin
        if (I_RESP_SEEN || !I_BUS_IDLE) begin
          next_ta_state = USBRM_TA_IDLE;
        end else if (bit_end) begin
          next_bt_cnt = 16'h0000;
          next_bits   = bits + 8'h01;
          if (bits == 8'(IDLE_BITS)) begin  // more than sixteen elapsed
            next_ta_timeout = 1'b1;
            next_ta_state   = USBRM_TA_IDLE;
          end
        end else begin
          next_bt_cnt = bt_cnt + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ta_state <= USBRM_TA_IDLE;
    end else begin
      ta_state <= next_ta_state;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bt_cnt <= 16'h0000;
      bits   <= 8'h00;
    end else begin
      bt_cnt <= next_bt_cnt;
      bits   <= next_bits;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ta_timeout <= 1'b0;
    end else begin
      ta_timeout <= next_ta_timeout;
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  logic [7:0] err_ev;
  logic [7:0] gen_ev;
  logic [7:0] otg_ev;
  logic       host_mode;
  logic       otg_clr;
  logic       gen_clr;
  logic       err_clr;
  logic [7:0] next_otg_if;
  logic [7:0] next_gen_if;
  logic [7:0] next_err_if;

  assign host_mode = con[`USBRM_HOSTEN_BIT];
  assign otg_ev    = I_OTG_EVENTS & `USBRM_OTGIR_MASK;
  assign otg_clr   = do_wr && (base_addr == `USBRM_OTGIR_OFS);
  assign gen_clr   = do_wr && (base_addr == `USBRM_IR_OFS);
  assign err_clr   = do_wr && (base_addr == `USBRM_EIR_OFS);

  always_comb begin
    err_ev = 8'h00;
    err_ev[`USBRM_PACKET_ID_CHECK_ERROR_FLAG_BIT]  = I_PID_BAD;
    err_ev[`USBRM_TOKEN_CHECKSUM_ERROR_FLAG_BIT] = host_mode ? (I_SOF_ZERO && I_XFER_ACTIVE)
                                          : I_TOKEN_CRC_BAD;
    err_ev[`USBRM_TURNAROUND_TIMEOUT_ERROR_FLAG_BIT]  = ta_timeout;
    err_ev[`USBRM_MEMORY_ACCESS_ERROR_FLAG_BIT]  = I_DMA_LATE || I_RX_TRUNC;
  end

  always_comb begin
    gen_ev = I_GEN_EVENTS;
    gen_ev[`USBRM_GENERAL_ERROR_INTERRUPT_FLAG_BIT] = |(err_if & err_ie);
  end

  // ----------------------------------------
  // flag slices, one per bit
  // ----------------------------------------
  // a same-cycle event beats the software clear, so no event is lost
  for (genvar b = 0; b < 8; b++) begin : g_flag
    assign next_otg_if[b] = (otg_if[b] && !(otg_clr && wd[b])) || otg_ev[b];
    assign next_gen_if[b] = (gen_if[b] && !(gen_clr && wd[b])) || gen_ev[b];
    assign next_err_if[b] = (err_if[b] && !(err_clr && wd[b])) || err_ev[b];
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      otg_if <= `USBRM_REG_RESET;
    end else begin
      otg_if <= next_otg_if;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gen_if <= `USBRM_REG_RESET;
    end else begin
      gen_if <= next_gen_if;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      err_if <= `USBRM_REG_RESET;
    end else begin
      err_if <= next_err_if;
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(gen_if & gen_ie) || |(otg_if & otg_ie);
    end
  end

endmodule

// ---- tb/usbrm_chk.sv ----
`timescale 1ns/1ps
module usbrm_chk (
  // bus side of the top module
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [15:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_IRQ
);
  // ------
  // checks
  // ------
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [11:0] pg;
  assign pg = I_PADDR[15:4];
  a_ready_next: assert property (I_PSEL && !I_PENABLE |=> O_PREADY) else $error("no ready");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("long ready");
  a_alias_ok: assert property (O_PREADY && (pg inside {12'h505, 12'h507, 12'h508, 12'h521, 12'h523,
    12'h525, 12'h526, 12'h527}) |-> !O_PSLVERR) else $error("alias refused");
  a_flag_clr_only: assert property (O_PREADY && (pg inside {12'h504, 12'h520, 12'h522})
    |-> O_PSLVERR == I_PADDR[3]) else $error("flag alias");
  a_status_base: assert property (O_PREADY && (pg inside {12'h506, 12'h524})
    |-> O_PSLVERR == (I_PADDR[3:2] != 2'h0)) else $error("status alias");
  a_err_access: assert property (O_PSLVERR |-> O_PREADY && I_PENABLE) else $error("stray error");
  a_upper_zero: assert property (O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == '0) else $error("upper bits");
  a_alias_rd: assert property (O_PREADY && !I_PWRITE && I_PADDR[3:2] != 2'h0 |-> O_PRDATA == '0)
    else $error("alias read");
  c_refused: cover property (O_PSLVERR);
  c_alias_wr: cover property (O_PREADY && I_PWRITE && I_PADDR[3:2] != 2'h0);
  c_irq: cover property ($rose(O_IRQ));
endmodule
bind usbrm_top usbrm_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));

// ---- tb/usbrm_link_model.sv ----
`timescale 1ns/1ps
module usbrm_link_model (
  // clock, reset, command
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_go,
  input  wire logic [2:0] i_kind,
  // resp, idle, eop, trunc, dma, xfer, sof, crc, pid
  output logic      [8:0] o_ev
);
  // ------
  // events
  // ------
  logic [7:0] hit;
  assign hit = i_go ? (8'h01 << i_kind) : 8'h00;
  // line stays idle unless a reply is commanded, so a silent peer times out
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ev <= 9'h080;
    end else begin
      o_ev <= {hit[7], ~hit[7], hit[6], hit[5], hit[4], hit[2], hit[2] | hit[3], hit[1], hit[0]};
    end
  end
endmodule

// ---- tb/usbrm_top_tb.sv ----
`timescale 1ns/1ps
module usbrm_top_tb import usbrm_pkg::*; ;
  logic        clk, rst_n, psel, penable, pwrite, go, pready, pslverr, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r, s, c, v;
  logic [7:0]  otg_ev, gen_ev, lines, xstat;
  logic [8:0]  ev;
  logic [2:0]  kind;
  logic [33:0] e, q[$];
  int          mismatches, total_checks;
  localparam logic [15:0] REGS [13] = '{16'h5040, 16'h5050, 16'h5060, 16'h5070, 16'h5080, 16'h5200,
    16'h5210, 16'h5220, 16'h5230, 16'h5240, 16'h5250, 16'h5260, 16'h5270};
  localparam logic [15:0] BAD [13] = '{16'h5048, 16'h504C, 16'h5208, 16'h520C, 16'h5228, 16'h522C,
    16'h5064, 16'h5068, 16'h506C, 16'h5244, 16'h5248, 16'h524C, 16'h5100};
  usbrm_top #(.IDLE_BITS(16), .BIT_CYCLES(1)) dut (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TOKEN_CRC_BAD(ev[1]), .I_SOF_ZERO(ev[2]), .I_XFER_ACTIVE(ev[3]), .I_PID_BAD(ev[0]),
    .I_DMA_LATE(ev[4]), .I_RX_TRUNC(ev[5]), .I_EOP(ev[6]), .I_BUS_IDLE(ev[7]), .I_RESP_SEEN(ev[8]),
    .I_OTG_EVENTS(otg_ev), .I_GEN_EVENTS(gen_ev), .I_OTG_LINES(lines), .I_XFER_STATUS(xstat), .O_IRQ(irq));
  usbrm_link_model u_link (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_kind(kind), .o_ev(ev));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    $display("mismatches %0d checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ------
  // apb master; expectation queued, judged by the monitor
  // ------
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic er, input logic [31:0] x);
    int n;
    q.push_back({~w, er, x});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk);
    if (n == 16) begin
      mismatches++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d); apb(1'b1, a, d, 1'b0, '0); endtask
  task rd(input logic [15:0] a, input logic [31:0] x); apb(1'b0, a, '0, 1'b0, x); endtask
  task fire(input logic [2:0] k);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task err_case(input logic [2:0] k, input logic [7:0] b);
    fire(k);
    rd(16'h5220, 32'(b));
    wr(16'h5220, 32'(b));
    rd(16'h5220, '0);
  endtask
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk(32'(pslverr), 32'(e[32]));
      if (e[33]) chk(prdata, e[31:0]);
    end
  end
  initial begin
    {psel, penable, pwrite, go, rst_n} = '0;
    {paddr, pwdata, kind, otg_ev, gen_ev, lines, xstat} = '0;
    void'($urandom(32'h6298250f));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (REGS[i]) rd(REGS[i], '0);
    $display("test reset done");
    r = $urandom;
    s = $urandom;
    c = $urandom;
    v = $urandom;
    wr(16'h5230, r);
    wr(16'h5238, s);
    wr(16'h5234, c);
    wr(16'h523C, v);
    rd(16'h5230, 32'(((r[7:0] | s[7:0]) & ~c[7:0]) ^ v[7:0]));
    rd(16'h5238, '0);
    wr(16'h5050, 32'hFFFF_FFFF);
    rd(16'h5050, 32'h0000_00FD);
    $display("test alias done");
    foreach (BAD[i]) apb(1'b1, BAD[i], 32'hFFFF_FFFF, 1'b1, '0);
    rd(16'h5220, '0);
    lines <= r[7:0];
    xstat <= s[7:0];
    rd(16'h5060, 32'(r[7:0] & 8'hAD));
    rd(16'h5240, 32'(s[7:0] & 8'hFC));
    $display("test refuse done");
    err_case(3'd0, 8'h01);
    err_case(3'd1, 8'h02);
    err_case(3'd4, 8'h20);
    err_case(3'd5, 8'h20);
    wr(16'h5250, 32'h0000_0008);
    err_case(3'd2, 8'h02);
    err_case(3'd3, 8'h00);
    fire(3'd6);
    fire(3'd7);
    repeat (20) @(posedge clk);
    rd(16'h5220, '0);
    fire(3'd6);
    repeat (20) @(posedge clk);
    rd(16'h5220, 32'h0000_0010);
    wr(16'h5220, 32'h0000_0010);
    $display("test error done");
    wr(16'h5230, 32'h0000_0001);
    wr(16'h5210, 32'h0000_0002);
    fire(3'd0);
    rd(16'h5200, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    wr(16'h5210, '0);
    repeat (2) @(posedge clk);
    chk(32'(irq), '0);
    wr(16'h5224, 32'h0000_0001);
    wr(16'h5200, 32'h0000_0002);
    rd(16'h5200, '0);
    wr(16'h5050, 32'h0000_0004);
    otg_ev <= 8'h06;
    gen_ev <= 8'h81;
    @(posedge clk);
    otg_ev <= 8'h00;
    gen_ev <= 8'h00;
    rd(16'h5040, 32'h0000_0004);
    rd(16'h5200, 32'h0000_0081);
    chk(32'(irq), 32'h0000_0001);
    wr(16'h5040, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(32'(irq), '0);
    $display("test irq done");
    stop_test;
  end
endmodule
